// >>> design/pmsc_i2c_slave.sv
`timescale 1ns/1ns
`include "pmsc_cfg.svh"
module pmsc_i2c_slave (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sel_i,     // filtered, select asserted
  input  wire logic scl_i,     // filtered clock level
  input  wire logic scl_rise,
  input  wire logic scl_fall,
  input  wire logic sda_i,     // filtered data level
  input  wire logic sda_rise,
  input  wire logic sda_fall,
  output logic      sda_oe,    // pull data low
  pmsc_mem_if.slave mem
);
  import pmsc_pkg::*;
  pmsc_sl_type    state_q, state_d;  // byte engine
  pmsc_phase_type phase_q, phase_d;  // write byte role
  logic [3:0]     cnt_q, cnt_d;      // bit count
  logic [7:0]     sh_q, sh_d;        // shift register
  logic [7:0]     ptr_q, ptr_d;      // map pointer
  logic           rw_q, rw_d;        // read transfer
  logic           oe_q, oe_d;
  logic           wr_d, rd_d;
  logic           start, stop;
  // start and stop: data moves while clock high
  assign start  = sda_fall & scl_i;
  assign stop   = sda_rise & scl_i;
  assign sda_oe = oe_q;
  assign mem.addr  = ptr_q;
  assign mem.wdata = sh_q;
  assign mem.wr    = wr_d;
  assign mem.rd    = rd_d;
  // ****************************************
  // byte engine
  // ****************************************
  // next state of the slave
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    oe_d    = oe_q;
    wr_d    = 1'b0;
    rd_d    = 1'b0;
    if (!sel_i) begin // R01
      state_d = SL_IDLE;
      oe_d    = 1'b0;
    end else if (start) begin
      state_d = SL_RX;
      phase_d = PH_DEV;
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
    end else if (stop) begin
      state_d = SL_IDLE;
      oe_d    = 1'b0;
    end else begin
      case (state_q)
        SL_RX: begin // R13
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_i};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_d   = 4'h0;
            state_d = SL_ACK;
            oe_d    = 1'b1;
            case (phase_q)
              PH_DEV: begin
                rw_d = sh_q[0];
                // other addresses: stay off the bus
                if (sh_q[7:1] != `PMSC_DEV_ADDR) begin
                  state_d = SL_IDLE;
                  oe_d    = 1'b0;
                end
              end
              PH_REG: ptr_d = sh_q;
              default: begin
                wr_d  = 1'b1;
                ptr_d = ptr_q + 8'h01;
              end
            endcase
          end
        end
        SL_ACK: begin
          if (scl_fall) begin
            oe_d    = 1'b0;
            state_d = SL_RX;
            if (phase_q == PH_DEV && rw_q) begin
              state_d = SL_TX;
              rd_d    = 1'b1;
              sh_d    = mem.rdata;
              oe_d    = ~mem.rdata[7];
            end else if (phase_q == PH_DEV) begin
              phase_d = PH_REG;
            end else begin
              phase_d = PH_DATA;
            end
          end
        end
        SL_TX: begin // R13
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              cnt_d   = 4'h0;
              oe_d    = 1'b0;
              state_d = SL_TACK;
              ptr_d   = ptr_q + 8'h01;
            end else begin
              cnt_d = cnt_q + 4'h1;
              sh_d  = {sh_q[6:0], 1'b0};
              oe_d  = ~sh_q[6];
            end
          end
        end
        SL_TACK: begin
          // master nack ends the read
          if (scl_rise && sda_i) begin
            state_d = SL_IDLE;
          end else if (scl_fall) begin
            state_d = SL_TX;
            rd_d    = 1'b1;
            sh_d    = mem.rdata;
            oe_d    = ~mem.rdata[7];
          end
        end
        default: state_d = SL_IDLE;
      endcase
    end
  end
  // register the slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SL_IDLE;
      phase_q <= PH_DEV;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_unsel_quiet: assert property (!sel_i |=> !oe_q ##1 !oe_q) // R01
    else $error("data driven while not selected");
  a_foreign_addr: assert property (sel_i && !start && !stop && state_q == SL_RX && scl_fall && cnt_q == 4'h8
      && phase_q == PH_DEV && sh_q[7:1] != `PMSC_DEV_ADDR |=> state_q == SL_IDLE && !oe_q) // R01
    else $error("foreign address acknowledged");
endmodule

// >>> design/pmsc_top.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "pmsc_cfg.svh"
module pmsc_top #(
  parameter int INIT_MS    = `PMSC_INIT_MS,
  parameter int RST_MIN_US = `PMSC_RST_MIN_US,
  parameter int INIT_W     = 27,
  parameter int RST_W      = 16
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  output logic                      irq,
  input  wire logic                 module_select_n,
  input  wire logic                 module_reset_n,
  input  wire logic                 low_power_select,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  output logic                      module_present_n,
  output logic                      interrupt_n_o,
  output logic                      interrupt_n_oe,
  output logic                      power_limit,
  output logic [`PMSC_CH_W-1:0]     tx_disable,
  output logic [`PMSC_CH_W-1:0]     rx_disable,
  output pmsc_pkg::pmsc_main_type   seq_state
);
  import pmsc_pkg::*;
  // least time rounds up, longest rounds down
  localparam longint RST_CYC  = (longint'(RST_MIN_US) * `PMSC_CLK_HZ + 999999) / 1000000;
  localparam longint INIT_CYC = longint'(INIT_MS) * (`PMSC_CLK_HZ / 1000);
  localparam logic [RST_W-1:0]  RST_LAST  = RST_W'(RST_CYC - 1);
  localparam logic [RST_W-1:0]  RST_SAT   = RST_W'(RST_CYC);
  localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYC - 1);
  // ****************************************
  // pin filters
  // ****************************************
  logic [`PMSC_PIN_W-1:0] s1_q, s2_q, s3_q; // three-stage synchroniser
  logic [`PMSC_PIN_W-1:0] flt_q, flt_d;     // agreed level
  logic [`PMSC_PIN_W-1:0] prev_q;           // for edges
  logic [`PMSC_PIN_W-1:0] pins;
  logic                   scl_rise, scl_fall, sda_rise, sda_fall;
  assign pins = {low_power_select, module_reset_n, module_select_n, sda_i, scl_i};
  // change counts only once stages two and three agree
  always_comb begin
    flt_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & flt_q);
  end
  // all pins idle high; reset pin high means no reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q   <= `PMSC_PIN_INIT;
      s2_q   <= `PMSC_PIN_INIT;
      s3_q   <= `PMSC_PIN_INIT;
      flt_q  <= `PMSC_PIN_INIT;
      prev_q <= `PMSC_PIN_INIT;
    end else begin
      s1_q   <= pins;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      flt_q  <= flt_d;
      prev_q <= flt_q;
    end
  end
  assign scl_rise = flt_q[`PMSC_PIN_SCL] & ~prev_q[`PMSC_PIN_SCL];
  assign scl_fall = ~flt_q[`PMSC_PIN_SCL] & prev_q[`PMSC_PIN_SCL];
  assign sda_rise = flt_q[`PMSC_PIN_SDA] & ~prev_q[`PMSC_PIN_SDA];
  assign sda_fall = ~flt_q[`PMSC_PIN_SDA] & prev_q[`PMSC_PIN_SDA];
  // ****************************************
  // reset and init sequencing
  // ****************************************
  pmsc_main_type     state_q, state_d;
  logic [RST_W-1:0]  rst_cnt_q, rst_cnt_d;   // low time of reset pin
  logic [INIT_W-1:0] init_cnt_q, init_cnt_d; // init duration
  logic              reset_hit;              // qualified reset pulse
  logic              done_ev;                // init finished
  // a pulse counts once, when it reaches the minimum
  assign reset_hit = ~flt_q[`PMSC_PIN_RST] & (rst_cnt_q == RST_LAST); // R17 R03
  always_comb begin
    rst_cnt_d  = rst_cnt_q;
    state_d    = state_q;
    init_cnt_d = init_cnt_q;
    done_ev    = 1'b0;
    // shorter glitches never reach the count
    if (flt_q[`PMSC_PIN_RST]) begin // R17
      rst_cnt_d = '0;
    end else if (rst_cnt_q != RST_SAT) begin
      rst_cnt_d = rst_cnt_q + 1'b1;
    end
    case (state_q)
      ST_HOLD: begin
        if (flt_q[`PMSC_PIN_RST]) begin
          state_d    = ST_INIT;
          init_cnt_d = '0;
        end
      end
      ST_INIT: begin // R16
        if (init_cnt_q == INIT_LAST) begin
          state_d = ST_READY;
          done_ev = 1'b1; // R05 R06
        end else begin
          init_cnt_d = init_cnt_q + 1'b1;
        end
      end
      ST_READY: state_d = ST_READY;
      default:  state_d = ST_INIT;
    endcase
    if (reset_hit) begin // R03
      state_d    = ST_HOLD;
      init_cnt_d = '0;
      done_ev    = 1'b0;
    end
  end
  // power-up enters init on its own, no pin pulse needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_INIT; // R06
      rst_cnt_q  <= '0;
      init_cnt_q <= '0;
    end else begin
      state_q    <= state_d;
      rst_cnt_q  <= rst_cnt_d;
      init_cnt_q <= init_cnt_d;
    end
  end
  // ****************************************
  // serial memory map
  // ****************************************
  pmsc_mem_if mem ();
  logic                  dnr_q, dnr_d;     // init pending
  logic [1:0]            flags_q, flags_d; // latched causes
  logic [`PMSC_CH_W-1:0] tx_q, tx_d, rx_q, rx_d;
  logic                  lp_q, lp_d;
  logic                  fault_ev;
  pmsc_i2c_slave u_slave (
    .pclk     (pclk),
    .presetn  (presetn),
    .sel_i    (~flt_q[`PMSC_PIN_SEL]),
    .scl_i    (flt_q[`PMSC_PIN_SCL]),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .sda_i    (flt_q[`PMSC_PIN_SDA]),
    .sda_rise (sda_rise),
    .sda_fall (sda_fall),
    .sda_oe   (sda_oe),
    .mem      (mem.slave)
  );
  // read mux, unmapped bytes read zero
  always_comb begin
    case (mem.addr)
      `PMSC_MAP_STATUS: mem.rdata = {6'h00, lp_q, dnr_q};
      `PMSC_MAP_FLAGS:  mem.rdata = {6'h00, flags_q};
      `PMSC_MAP_TXDIS:  mem.rdata = {4'h0, tx_q};
      `PMSC_MAP_RXDIS:  mem.rdata = {4'h0, rx_q};
      default:          mem.rdata = 8'h00;
    endcase
  end
  // settings: channel shutdown, flags, power mode
  always_comb begin
    dnr_d   = (state_d != ST_READY); // R18
    flags_d = flags_q;
    tx_d    = tx_q;
    rx_d    = rx_q;
    lp_d    = flt_q[`PMSC_PIN_LP]; // R07
    if (mem.rd && mem.addr == `PMSC_MAP_FLAGS) begin
      flags_d = 2'h0;
    end
    // set after the read clear; only reset_hit in the same cycle drops a fresh event
    if (done_ev) begin
      flags_d[`PMSC_FLAG_DONE] = 1'b1; // R05
    end
    if (fault_ev) begin
      flags_d[`PMSC_FLAG_FAULT] = 1'b1; // R10
    end
    if (mem.wr && mem.addr == `PMSC_MAP_TXDIS) begin
      tx_d = mem.wdata[`PMSC_CH_W-1:0]; // R14
    end
    if (mem.wr && mem.addr == `PMSC_MAP_RXDIS) begin
      rx_d = mem.wdata[`PMSC_CH_W-1:0]; // R14
    end
    if (reset_hit) begin // R03
      flags_d = 2'h0;
      tx_d    = '0;
      rx_d    = '0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dnr_q   <= 1'b1;
      flags_q <= 2'h0;
      tx_q    <= '0;
      rx_q    <= '0;
      lp_q    <= 1'b1;
    end else begin
      dnr_q   <= dnr_d;
      flags_q <= flags_d;
      tx_q    <= tx_d;
      rx_q    <= rx_d;
      lp_q    <= lp_d;
    end
  end
  // ****************************************
  // apb slave and interrupt
  // ****************************************
  logic                  rdy_q, rdy_d, err_q, err_d, irq_q, irq_d, oe_q, oe_d;
  logic [31:0]           rd_q, rd_d;
  logic [`PMSC_IRQ_W-1:0] istat_q, istat_d, imask_q, imask_d;
  logic                  take, acc, wr_take;
  assign acc      = psel & penable;
  assign take     = acc & rdy_q;
  assign wr_take  = take & pwrite;
  assign fault_ev = wr_take & (paddr == `PMSC_A_CTRL) & pwdata[0];
  // one wait state: ready rises in the second access cycle
  always_comb begin
    rdy_d   = acc & ~rdy_q;
    err_d   = 1'b0;
    rd_d    = rd_q;
    imask_d = imask_q;
    istat_d = istat_q;
    if (acc && !rdy_q) begin
      case (paddr)
        `PMSC_A_CTRL:   rd_d = 32'h0000_0000;
        `PMSC_A_STATUS: rd_d = {16'h0000, rx_q, tx_q, 4'h0, (state_q == ST_HOLD),
                                ~flt_q[`PMSC_PIN_SEL], lp_q, dnr_q};
        `PMSC_A_ISTAT:  rd_d = {29'h0, istat_q};
        `PMSC_A_IMASK:  rd_d = {29'h0, imask_q};
        default: begin
          rd_d  = 32'h0000_0000;
          err_d = 1'b1;
        end
      endcase
    end
    if (wr_take && paddr == `PMSC_A_IMASK) begin
      imask_d = pwdata[`PMSC_IRQ_W-1:0];
    end
    if (wr_take && paddr == `PMSC_A_ISTAT) begin
      istat_d = istat_q & ~pwdata[`PMSC_IRQ_W-1:0];
    end
    // events after the clear: set wins
    istat_d[`PMSC_IRQ_DONE] = istat_d[`PMSC_IRQ_DONE] | done_ev;
    istat_d[`PMSC_IRQ_HWR]  = istat_d[`PMSC_IRQ_HWR] | mem.wr;
    istat_d[`PMSC_IRQ_RST]  = istat_d[`PMSC_IRQ_RST] | reset_hit;
    irq_d = |(istat_q & imask_q);
    oe_d  = |flags_q; // R10 R12
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rd_q    <= 32'h0000_0000;
      istat_q <= '0;
      imask_q <= '0;
      irq_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      rd_q    <= rd_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      irq_q   <= irq_d;
      oe_q    <= oe_d;
    end
  end
  // open-drain pins only ever pull low
  assign pready           = rdy_q;
  assign pslverr          = err_q;
  assign prdata           = rd_q;
  assign irq              = irq_q;
  assign interrupt_n_oe   = oe_q;
  assign interrupt_n_o    = 1'b0; // R12 R15
  assign sda_o            = 1'b0; // R15
  assign module_present_n = 1'b0; // R08 R15
  assign power_limit      = lp_q;
  assign tx_disable       = tx_q;
  assign rx_disable       = rx_q;
  assign seq_state        = state_q;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_apb_answer: assert property (s_setup ##1 s_access |-> !rdy_q ##1 rdy_q)
    else $error("apb answer not one wait state");
  a_int_flags: assert property (flags_q != 2'h0 |=> interrupt_n_oe) // R10
    else $error("interrupt not pulled with cause latched");
  a_int_release: assert property (flags_q == 2'h0 |=> !interrupt_n_oe && !interrupt_n_o) // R12
    else $error("interrupt pin not released");
  a_done_post: assert property (state_q == ST_INIT && done_ev |=> flags_q[`PMSC_FLAG_DONE] && !dnr_q
      && interrupt_n_oe == 1'b0 ##1 interrupt_n_oe) // R05
    else $error("completion not posted");
  a_reset_defaults: assert property (reset_hit |=> dnr_q && tx_q == '0 && rx_q == '0
      && flags_q == 2'h0 && state_q == ST_HOLD) // R03 R18
    else $error("reset did not restore defaults");
  a_reset_min: assert property (state_q != ST_HOLD ##1 state_q == ST_HOLD |-> $past(rst_cnt_q) == RST_LAST) // R17
    else $error("reset pulse shorter than minimum accepted");
  a_init_bound: assert property (state_q == ST_INIT |-> init_cnt_q <= INIT_LAST) // R16
    else $error("init exceeds maximum time");
  a_pending_hold: assert property (state_q == ST_HOLD |=> dnr_q) // R18
    else $error("pending flag cleared during reset");
  a_lp_follow: assert property (flt_q[`PMSC_PIN_LP] != power_limit |=> power_limit == $past(flt_q[`PMSC_PIN_LP])) // R07
    else $error("power limit not following pin");
  a_chan_write: assert property (mem.wr && mem.addr == `PMSC_MAP_TXDIS && !reset_hit
      |=> tx_disable == $past(mem.wdata[`PMSC_CH_W-1:0])) // R14
    else $error("channel shutdown not stored");
endmodule

// >>> inc/pmsc_cfg.svh
// What this block and its host must do
// R01: answer serial bus only while selected
// R02: host gives each module own select
// R03: long reset pulse restores all defaults
// R04: host ignores status during reset
// R05: reset done raises interrupt, clears pending
// R06: power-up raises same completion interrupt
// R07: low-power pin sets power limit
// R08: present output tied low when inserted
// R09: host pulls present signal up
// R10: interrupt pin low reports fault/status
// R11: host reads map to find cause
// R12: interrupt pin only pulls low, host pulls up
// R13: map read/write over serial clock, data
// R14: each channel individually shut down
// R15: exactly seven low-speed control pins
// R16: initialization done within maximum time
// R17: reset pulse minimum is parameter, filtered
// R18: pending flag set from reset to done
`ifndef PMSC_CFG_SVH
`define PMSC_CFG_SVH
// ****************************************
// timing
// ****************************************
`define PMSC_CLK_HZ      50000000
`define PMSC_INIT_MS     2000
`define PMSC_RST_MIN_US  10
// ****************************************
// pins, channels
// ****************************************
`define PMSC_PIN_W       5
`define PMSC_PIN_INIT    5'h1f
`define PMSC_PIN_SCL     0
`define PMSC_PIN_SDA     1
`define PMSC_PIN_SEL     2
`define PMSC_PIN_RST     3
`define PMSC_PIN_LP      4
`define PMSC_CH_W        4
// ****************************************
// serial memory map
// ****************************************
`define PMSC_DEV_ADDR    7'h50
`define PMSC_MAP_STATUS  8'h02
`define PMSC_MAP_FLAGS   8'h03
`define PMSC_MAP_TXDIS   8'h56
`define PMSC_MAP_RXDIS   8'h57
`define PMSC_FLAG_DONE   0
`define PMSC_FLAG_FAULT  1
// ****************************************
// apb registers
// ****************************************
`define PMSC_A_CTRL      12'h000
`define PMSC_A_STATUS    12'h004
`define PMSC_A_ISTAT     12'h008
`define PMSC_A_IMASK     12'h00c
`define PMSC_IRQ_W       3
`define PMSC_IRQ_DONE    0
`define PMSC_IRQ_HWR     1
`define PMSC_IRQ_RST     2
`endif

// >>> inc/pmsc_mem_if.sv
`timescale 1ns/1ns
// byte access from serial slave to memory map
interface pmsc_mem_if;
  logic [7:0] addr;   // map byte address
  logic [7:0] wdata;  // write byte
  logic [7:0] rdata;  // read byte, combinational
  logic       wr;     // one-cycle write strobe
  logic       rd;     // one-cycle read strobe
  modport slave (output addr, output wdata, output wr, output rd, input rdata);
  modport map   (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// >>> inc/pmsc_pkg.sv
package pmsc_pkg;
  // sideband sequencing
  typedef enum logic [1:0] {ST_HOLD, ST_INIT, ST_READY} pmsc_main_type;
  // serial slave states
  typedef enum logic [2:0] {SL_IDLE, SL_RX, SL_ACK, SL_TX, SL_TACK} pmsc_sl_type;
  // which byte of a write comes next
  typedef enum logic [1:0] {PH_DEV, PH_REG, PH_DATA} pmsc_phase_type;
endpackage

// >>> tb/pmsc_host_model.sv
`timescale 1ns/1ns
`include "pmsc_cfg.svh"
// host board: 2-wire master, pull-ups on open-drain lines
module pmsc_host_model (
  input  wire logic pclk,
  input  wire logic dut_sda_oe,
  input  wire logic dut_int_oe,
  input  wire logic dut_prs_n,
  output logic      scl,
  output logic      sda,
  output logic      int_line,
  output logic      prs_line
);
  logic drv_q;  // host pulls data low
  initial begin
    scl = 1'b1;
    drv_q = 1'b0;
  end
  // ****************************************
  // wired lines
  // ****************************************
  assign sda      = ~(drv_q | dut_sda_oe);
  assign int_line = ~dut_int_oe;
  assign prs_line = (dut_prs_n === 1'b0) ? 1'b0 : 1'b1;
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // byte plus ack slot, msb first; long low phase leaves room for the slave
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      scl <= 1'b0;
      w(3);
      drv_q <= ~d[i];
      w(3);
      scl <= 1'b1;
      w(2);
      r[i] = sda;
    end
  endtask
  // stop: data rises while clock high, then bus idles released
  task automatic halt();
    scl <= 1'b0;
    w(3);
    drv_q <= 1'b1;
    w(3);
    scl <= 1'b1;
    w(4);
    drv_q <= 1'b0;
    w(4);
  endtask
  // start, one address byte, stop; ok is the ack seen
  task automatic probe(input logic [6:0] da, output logic ok);
    logic [8:0] r0;
    drv_q <= 1'b1;  // start
    w(4);
    xfer({da, 1'b0, 1'b1}, r0);
    ok = !r0[0];
    halt();
  endtask
  // two-byte write at a, or pointer set then two-byte read
  task automatic frame(input logic rd, input logic [7:0] a, input logic [15:0] wd,
                       output logic [15:0] q, output logic ok);
    logic [8:0] r0, r1, r2, r3, r4;
    r4 = 9'h0;
    drv_q <= 1'b1;  // start
    w(4);
    xfer({`PMSC_DEV_ADDR, 1'b0, 1'b1}, r0);
    xfer({a, 1'b1}, r1);
    if (rd) begin
      scl <= 1'b0;
      w(3);
      drv_q <= 1'b0;
      w(3);
      scl <= 1'b1;
      w(4);
      drv_q <= 1'b1;  // repeated start
      w(4);
      xfer({`PMSC_DEV_ADDR, 1'b1, 1'b1}, r4);
      xfer(9'h1fe, r2);  // ack first byte
      xfer(9'h1ff, r3);  // nack ends the read
    end else begin
      xfer({wd[15:8], 1'b1}, r2);
      xfer({wd[7:0], 1'b1}, r3);
    end
    ok = !r0[0] && !r1[0] && (rd ? !r4[0] : !r2[0] && !r3[0]);
    q = {r2[8:1], r3[8:1]};
    halt();
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb;
  import pmsc_pkg::*;
  localparam int INIT_CYC = 50000;  // INIT_MS of 1 at 50 MHz
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ok, err;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rv;
  logic          sel_n, rst_n, lp, scl, sda, sda_oe, prs_n, int_oe, plim, int_line, prs_line, sda_o, int_o;
  logic [3:0]    txd, rxd;
  logic [7:0]    t, r;
  logic [15:0]   q;
  pmsc_main_type st;
  int            num_errors, checks_done, n;
  pmsc_top #(.INIT_MS(1)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq(irq), .module_select_n(sel_n), .module_reset_n(rst_n), .low_power_select(lp), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .module_present_n(prs_n), .interrupt_n_o(int_o),
    .interrupt_n_oe(int_oe), .power_limit(plim), .tx_disable(txd), .rx_disable(rxd), .seq_state(st));
  pmsc_host_model u_host (.pclk(pclk), .dut_sda_oe(sda_oe), .dut_int_oe(int_oe), .dut_prs_n(prs_n),
    .scl(scl), .sda(sda), .int_line(int_line), .prs_line(prs_line));
  // ****************************************
  // tasks
  // ****************************************
  task automatic final_report();
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      final_report();
    end
    // one idle edge, so a following call never drives psel twice in one step
    @(posedge pclk);
  endtask
  task automatic wait_st(input pmsc_main_type s, input int lim);
    n = 0;
    while (st !== s && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (st !== s) begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hd82f3832));
    {presetn, psel, penable, pwrite, paddr, pwdata, sel_n, lp} = '0;
    rst_n = 1'b1;
    num_errors = 0;
    checks_done = 0;
    cyc(2);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("present", 1'b0, prs_line)
    wait_st(ST_READY, INIT_CYC + 20);
    `CHK("init time", 1'b1, n > INIT_CYC - 4)
    cyc(2);
    `CHK("int pin", 1'b0, int_line)
    `CHK("drive level", 2'b00, {sda_o, int_o})
    // first status poll comes after completion
    u_host.frame(1'b1, 8'h02, 16'h0, q, ok);
    `CHK("pending and done", 16'h0001, q)
    `CHK("int released", 1'b1, int_line)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, 12'h00c, 32'h7);
    cyc(2);
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, 12'h008, 32'h7);
    cyc(2);
    `CHK("irq off", 1'b0, irq)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rv})
    for (int i = 0; i < 4; i++) begin
      lp <= 1'($urandom_range(1));
      cyc(8);
      `CHK("power limit", lp, plim)
    end
    for (int i = 0; i < 3; i++) begin
      t = 8'($urandom_range(15));
      r = (i == 0) ? 8'h0f : 8'($urandom_range(15));
      sel_n <= 1'b0;
      cyc(8);
      u_host.frame(1'b0, 8'h56, {t, r}, q, ok);
      cyc(8);
      `CHK("channels", {1'b1, t[3:0], r[3:0]}, {ok, txd, rxd})
      u_host.frame(1'b1, 8'h56, 16'h0, q, ok);
      `CHK("read back", {t, r}, q)
      sel_n <= 1'b1;
      cyc(8);
      u_host.frame(1'b0, 8'h56, ~{t, r}, q, ok);
      `CHK("deselected", {1'b0, t[3:0], r[3:0]}, {ok, txd, rxd})
    end
    sel_n <= 1'b0;
    apb(1'b0, 12'h008, 32'h0);
    `CHK("map write event", 2'b11, {rv[1], irq})
    apb(1'b1, 12'h000, 32'h1);
    cyc(4);
    `CHK("fault pin", 1'b0, int_line)
    u_host.frame(1'b1, 8'h03, 16'h0, q, ok);
    `CHK("fault flag", 16'h0200, q)
    u_host.probe(7'h51, ok);
    `CHK("foreign address", 1'b0, ok)
    rst_n <= 1'b0;
    cyc(450);
    rst_n <= 1'b1;
    cyc(8);
    `CHK("short pulse", ST_READY, st)
    rst_n <= 1'b0;
    cyc(520);
    `CHK("held", ST_HOLD, st)
    `CHK("defaults", 8'h0, {txd, rxd})
    apb(1'b0, 12'h004, 32'h0);
    `CHK("hold status", 32'h9, rv & 32'h9)
    rst_n <= 1'b1;
    wait_st(ST_INIT, 16);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("reset seen", 1'b1, rv[2])
    u_host.frame(1'b1, 8'h02, 16'h0, q, ok);
    `CHK("pending", 1'b1, q[8])
    final_report();
  end
endmodule
